// [verif/i2m_slave_model.sv]
// Behavioural slave that serves one byte per arm pulse and may stretch the clock.
`timescale 1ns/1ps
module i2m_slave_model (
  // Clock
  input wire logic clk_sys,
  // Bus line and command
  input wire logic scl_i,
  input wire logic arm,
  input wire logic [7:0] tx_byte,
  input wire logic [3:0] stretch,
  // Open-drain releases, high means released
  output logic scl_rel,
  output logic sda_rel
);
  logic scl_d_r = 1'b1;
  logic sda_r = 1'b1;
  logic [7:0] sh_r = 8'hFF;
  logic [3:0] left_r = 4'h0;
  logic [3:0] hold_r = 4'h0;
  logic fell;

  assign fell = scl_d_r & ~scl_i;
  assign scl_rel = (hold_r == 4'h0);
  assign sda_rel = sda_r;

  // ------------------------------------------------------------
  // Data out MSB first, new bit after each falling clock edge
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    scl_d_r <= scl_i;
    if (arm) begin
      sh_r <= {tx_byte[6:0], 1'b1};
      left_r <= 4'h8;
      sda_r <= tx_byte[7];
    end else if (fell && left_r != 4'h0) begin
      left_r <= left_r - 4'h1;
      sh_r <= {sh_r[6:0], 1'b1};
      sda_r <= (left_r == 4'h1) ? 1'b1 : sh_r[7];
      hold_r <= stretch;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end
endmodule

// [verif/tb_i2m_master.sv]
// Self-checking testbench of the two-wire bus master sequencer.
`timescale 1ns/1ps
module tb_i2m_master;
  import i2m_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  i2m_av_req_type av_req = '0;
  logic [31:0] av_readdata;
  logic av_waitrequest;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n;
  logic slv_scl_rel, slv_sda_rel;
  logic tb_scl_low = 1'b0;
  logic tb_sda_low = 1'b0;
  logic arm = 1'b0;
  logic [7:0] slv_byte = 8'h00;
  logic [3:0] stretch = 4'h0;
  logic scl_d = 1'b1;
  logic [15:0] cap = 16'h0000;
  logic [31:0] rd;
  logic [7:0] dat;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  wire scl_line = scl_oe_n & slv_scl_rel & ~tb_scl_low;
  wire sda_line = sda_oe_n & slv_sda_rel & ~tb_sda_low;

  i2m_master uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .av_req(av_req), .av_readdata(av_readdata),
    .av_waitrequest(av_waitrequest), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n));
  i2m_slave_model slv (.clk_sys(clk_sys), .scl_i(scl_line), .arm(arm), .tx_byte(slv_byte),
    .stretch(stretch), .scl_rel(slv_scl_rel), .sda_rel(slv_sda_rel));

  always #10 clk_sys = ~clk_sys;

  // ------------------------------------------------------------
  // Wire monitor and timeout
  // ------------------------------------------------------------
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    scl_d <= scl_line;
    if (scl_line && !scl_d) begin
      cap <= {cap[14:0], sda_line};
    end
    if (cyc == 60000) begin
      fail_count++;
      report_and_stop;
    end
  end

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    av_req.read <= ~wr;
    av_req.write <= wr;
    av_req.address <= a;
    av_req.writedata <= d;
    do @(posedge clk_sys); while (av_waitrequest !== 1'b0);
    rd = av_readdata;
    av_req.read <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic rbit(input logic [2:0] a, input int b, input string nm, input logic v);
    bus(1'b0, a, 32'h0);
    chk(nm, 32'(rd[b]), 32'(v));
  endtask

  task automatic wait_on(input logic [2:0] a, input int b, input logic v);
    int i;
    for (i = 0; i < 400; i++) begin
      bus(1'b0, a, 32'h0);
      if (rd[b] === v) break;
    end
    chk("wait", 32'(rd[b]), 32'(v));
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(10484));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    bus(1'b1, 3'h5, 32'h0000_00FF);
    for (int a = 0; a < 6; a++) begin
      bus(1'b0, a[2:0], 32'h0);
      chk("reset value", rd, 32'h0);
    end
    chk("lines idle", 32'({scl_oe_n, sda_oe_n}), 32'h3);
    chk("line drive", 32'({scl_o, sda_o}), 32'h0);
    bus(1'b1, OFS_RELOAD, 32'h0000_0003);
    bus(1'b0, OFS_RELOAD, 32'h0);
    chk("reload", rd, 32'h0000_0003);
    tb_sda_low <= 1'b1;
    repeat (8) @(posedge clk_sys);
    tb_scl_low <= 1'b1;
    repeat (8) @(posedge clk_sys);
    tb_sda_low <= 1'b0;
    rbit(OFS_STATUS, ST_START, "start seen", 1'b1);
    rbit(OFS_FLAGS, FL_EVENT, "start event", 1'b1);
    bus(1'b1, OFS_FLAGS, 32'h0000_000F);
    dat = {7'($urandom), 1'b1};
    bus(1'b1, OFS_BUFFER, 32'(dat));
    tb_scl_low <= 1'b0;
    wait_on(OFS_FLAGS, FL_EVENT, 1'b1);
    chk("address byte", 32'(cap[8:1]), 32'(dat));
    for (int k = 0; k < 4; k++) begin
      dat = 8'($urandom);
      stretch <= 4'($urandom_range(5, 0));
      bus(1'b1, OFS_FLAGS, 32'h0000_000F);
      slv_byte <= dat;
      arm <= 1'b1;
      @(posedge clk_sys);
      arm <= 1'b0;
      bus(1'b1, OFS_CTRL2, 32'h1 << CT_RX);
      if (k == 0) bus(1'b1, OFS_BUFFER, 32'h0000_00A5);
      if (k == 1) bus(1'b1, OFS_CTRL2, 32'h1 << CT_ACK);
      wait_on(OFS_FLAGS, FL_EVENT, 1'b1);
      rbit(OFS_STATUS, ST_FULL, "full after rx", 1'b1);
      bus(1'b0, OFS_FLAGS, 32'h0);
      chk("write collision", 32'(rd[FL_WRCOL]), 32'(k == 0));
      chk("overflow", 32'(rd[FL_OVF]), 32'(k == 2));
      rbit(OFS_CTRL2, CT_RX, "rx go cleared", 1'b0);
      rbit(OFS_CTRL2, CT_ACK, "go ignored", 1'b0);
      chk("scl held low", 32'(scl_oe_n), 32'h0);
      if (k != 1) begin
        bus(1'b0, OFS_BUFFER, 32'h0);
        if (k != 2) chk("rx byte", rd, 32'(dat));
        rbit(OFS_STATUS, ST_FULL, "full cleared", 1'b0);
      end
      bus(1'b1, OFS_FLAGS, 32'h0000_000F);
      bus(1'b1, OFS_CTRL2, (32'(k == 3) << CT_ACKV) | (32'h1 << CT_ACK));
      if (k == 2) bus(1'b1, OFS_CTRL2, 32'h1 << CT_RX);
      wait_on(OFS_FLAGS, FL_EVENT, 1'b1);
      chk("ack bit", 32'(cap[0]), 32'(k == 3));
      rbit(OFS_CTRL2, CT_ACK, "ack go cleared", 1'b0);
      rbit(OFS_CTRL2, CT_RX, "rx ignored", 1'b0);
    end
    bus(1'b1, OFS_FLAGS, 32'h0000_000F);
    bus(1'b1, OFS_CTRL2, 32'h1 << CT_STOP);
    wait_on(OFS_CTRL2, CT_STOP, 1'b0);
    rbit(OFS_FLAGS, FL_EVENT, "stop event", 1'b1);
    rbit(OFS_STATUS, ST_STOP_SEEN, "stop seen", 1'b1);
    chk("stop lines", 32'({scl_oe_n, sda_oe_n}), 32'h3);
    bus(1'b1, OFS_FLAGS, 32'h0000_000F);
    tb_sda_low <= 1'b1;
    bus(1'b1, OFS_BUFFER, 32'h0000_00FF);
    wait_on(OFS_FLAGS, FL_COLL, 1'b1);
    rbit(OFS_STATUS, ST_FULL, "full after coll", 1'b0);
    chk("coll lines", 32'({scl_oe_n, sda_oe_n}), 32'h3);
    bus(1'b1, OFS_FLAGS, 32'h0000_000F);
    tb_sda_low <= 1'b0;
    wait_on(OFS_FLAGS, FL_EVENT, 1'b1);
    rbit(OFS_STATUS, ST_STOP_SEEN, "stop watched", 1'b1);
    bus(1'b1, OFS_FLAGS, 32'h0000_000F);
    bus(1'b1, OFS_CTRL2, 32'h1 << CT_STOP);
    tb_sda_low <= 1'b1;
    wait_on(OFS_FLAGS, FL_COLL, 1'b1);
    rbit(OFS_CTRL2, CT_STOP, "stop aborted", 1'b0);
    chk("abort lines", 32'({scl_oe_n, sda_oe_n}), 32'h3);
    tb_sda_low <= 1'b0;
    repeat (20) @(posedge clk_sys);
    report_and_stop;
  end
endmodule

// [verilog/i2m_master.sv]
// Two-wire bus master sequencer: receive, transmit, acknowledge, stop and collision handling.
//
// Notes on behaviour
// - First byte of a read is seven address bits then a one.
// - Receive-go starts one byte; ignored unless the sequencer is idle.
// - Each rate rollover toggles SCL while received SDA bits shift in.
// - After eighth falling edge: clear go, load buffer, flag, hold SCL low.
// - Loading the buffer sets buffer-full; reading the buffer clears it.
// - A byte arriving while buffer-full is set raises receive-overflow.
// - Buffer write while busy raises write-collision and keeps buffer contents.
// - Acknowledge-go pulls SCL low and drives SDA with the acknowledge value.
// - Acknowledge: period low, release SCL, wait high, period, pull low, idle.
// - Stop-go drives SDA low, period, releases SCL, period, releases SDA.
// - SDA rising while SCL high is a stop and sets stop-seen.
// - After SDA release one more period, then clear stop-go and flag.
// - Every detected start or stop condition sets the event flag.
// - After SCL release the counter waits for SCL high, then reloads.
// - Expected high SDA sampled low is a collision; flag it and go idle.
// - Transmit collision halts, clears buffer-full, releases lines, frees buffer writes.
// - Sequence collision aborts, releases both lines, clears go bits.
// - After collision keep watching the bus; next buffer write restarts cleanly.
`timescale 1ns/1ps
module i2m_master (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register bus
  input wire i2m_pkg::i2m_av_req_type av_req,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // Bus lines
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n
);
  import i2m_pkg::*;
  // ----------------------------------------------------------------
  // Line synchronisers and condition detection
  // ----------------------------------------------------------------
  logic scl_m_r, scl_s, scl_d_r;
  logic sda_m_r, sda_s, sda_d_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_m_r <= 1'b1;
      scl_s <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_m_r <= scl_i;
      scl_s <= scl_m_r;
      scl_d_r <= scl_s;
      sda_m_r <= sda_i;
      sda_s <= sda_m_r;
      sda_d_r <= sda_s;
    end
  end
  wire start_det = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_det = scl_s && scl_d_r && !sda_d_r && sda_s;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  i2m_state_type state_r;
  i2m_phase_type phase_r;
  logic [3:0] bit_r;
  logic [6:0] cnt_r;
  logic run_r;
  logic [6:0] reload_r;
  logic [7:0] shift_r;
  logic [7:0] data_r;
  logic buffer_full_r;
  logic rx_go_r, ack_go_r, stop_go_r, ack_value_r;
  logic start_seen_r, stop_seen_r, ackstat_r;
  logic [3:0] flags_r;
  logic scl_oe_n_r, sda_oe_n_r;
  logic ack_r;
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  wire req_any = av_req.read || av_req.write;
  wire acc = req_any && ack_r;
  wire wr = acc && av_req.write;
  wire rd = acc && av_req.read;
  wire wr_ctrl = wr && (av_req.address == OFS_CTRL2);
  wire wr_flags = wr && (av_req.address == OFS_FLAGS);
  wire wr_buf = wr && (av_req.address == OFS_BUFFER);
  wire wr_reload = wr && (av_req.address == OFS_RELOAD);
  wire rd_buf = rd && (av_req.address == OFS_BUFFER);
  wire [31:0] wd = av_req.writedata;
  wire go_free = (state_r == ST_IDLE) && !rx_go_r && !ack_go_r && !stop_go_r;
  wire go_stop = wr_ctrl && go_free && wd[CT_STOP];
  wire go_ack = wr_ctrl && go_free && !wd[CT_STOP] && wd[CT_ACK];
  wire go_rx = wr_ctrl && go_free && !wd[CT_STOP] && !wd[CT_ACK] && wd[CT_RX];
  wire buf_ok = wr_buf && (state_r == ST_IDLE);
  wire wrcol_set = wr_buf && (state_r != ST_IDLE);
  wire [31:0] ctrl_val = {26'h0, ack_value_r, ack_go_r, rx_go_r, stop_go_r, 2'h0};
  wire [31:0] status_val = {25'h0, ackstat_r, 1'b0, stop_seen_r, start_seen_r, 2'h0, buffer_full_r};
  wire [31:0] rd_mux = (av_req.address == OFS_CTRL2) ? ctrl_val :
                       (av_req.address == OFS_STATUS) ? status_val :
                       (av_req.address == OFS_FLAGS) ? {28'h0, flags_r} :
                       (av_req.address == OFS_BUFFER) ? {24'h0, data_r} :
                       (av_req.address == OFS_RELOAD) ? {25'h0, reload_r} : 32'h0;
  assign av_waitrequest = req_any && !ack_r;
  assign av_readdata = rdata_r;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      ack_r <= req_any && !ack_r;
      if (req_any && !ack_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence events
  // ----------------------------------------------------------------
  wire tick = run_r && (cnt_r == 7'h00);
  wire high_end = tick && (phase_r == PH_HIGH);
  wire [7:0] shift_in = {shift_r[6:0], sda_s};
  wire rx_done = (state_r == ST_RX) && high_end && (bit_r == LAST_BIT);
  wire tx_last = (state_r == ST_TX) && high_end && (bit_r == LAST_BIT);
  wire tx_coll = (state_r == ST_TX) && (phase_r == PH_HIGH) && sda_oe_n_r && !sda_s && (bit_r != ACK_BIT);
  wire ack_coll = (state_r == ST_ACK) && (phase_r == PH_HIGH) && sda_oe_n_r && !sda_s;
  wire stop_coll = (state_r == ST_STOP) &&
                   (((phase_r == PH_HIGH) && !scl_s) || ((phase_r == PH_TAIL) && tick && !sda_s));
  wire coll = tx_coll || ack_coll || stop_coll;
  wire seq_done = (((state_r == ST_TX) && (bit_r == ACK_BIT)) || (state_r == ST_ACK)) && high_end;
  wire stop_done = (state_r == ST_STOP) && (phase_r == PH_TAIL) && tick && sda_s;
  // conditions and completions raise the event flag.
  wire event_set = rx_done || seq_done || stop_done || start_det || stop_det;
  wire [3:0] flag_set = {rx_done && buffer_full_r, wrcol_set, coll, event_set};
  wire [3:0] flag_clr = wr_flags ? wd[3:0] : 4'h0;

  // ----------------------------------------------------------------
  // Flags, buffer and registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags_r <= 4'h0;
      buffer_full_r <= 1'b0;
      data_r <= RST_BYTE;
      reload_r <= RST_RELOAD;
      start_seen_r <= 1'b0;
      stop_seen_r <= 1'b0;
    end else begin
      flags_r <= (flags_r & ~flag_clr) | flag_set;
      if (rx_done || buf_ok) begin
        buffer_full_r <= 1'b1;
      end else if (rd_buf || tx_last || coll) begin
        buffer_full_r <= 1'b0;
      end
      if (rx_done) begin
        data_r <= shift_in;
      end else if (buf_ok) begin
        data_r <= wd[7:0];
      end
      if (wr_reload) begin
        reload_r <= wd[6:0];
      end
      if (start_det) begin
        start_seen_r <= 1'b1;
        stop_seen_r <= 1'b0;
      end else if (stop_det) begin
        start_seen_r <= 1'b0;
        stop_seen_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bit and sequence engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      phase_r <= PH_LOW;
      bit_r <= 4'h0;
      cnt_r <= 7'h00;
      run_r <= 1'b0;
      shift_r <= RST_BYTE;
      rx_go_r <= 1'b0;
      ack_go_r <= 1'b0;
      stop_go_r <= 1'b0;
      ack_value_r <= 1'b0;
      ackstat_r <= 1'b0;
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      if (run_r && (cnt_r != 7'h00)) begin
        cnt_r <= cnt_r - 7'h01;
      end
      if (wr_ctrl && go_free) begin
        ack_value_r <= wd[CT_ACKV];
      end
      if (coll) begin
        // abort, release both lines, clear go bits.
        state_r <= ST_IDLE;
        phase_r <= PH_LOW;
        run_r <= 1'b0;
        rx_go_r <= 1'b0;
        ack_go_r <= 1'b0;
        stop_go_r <= 1'b0;
        scl_oe_n_r <= 1'b1;
        sda_oe_n_r <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
            phase_r <= PH_LOW;
            bit_r <= 4'h0;
            cnt_r <= reload_r;
            if (go_rx) begin
              state_r <= ST_RX;
              rx_go_r <= 1'b1;
              run_r <= 1'b1;
              scl_oe_n_r <= 1'b0;
              sda_oe_n_r <= 1'b1;
            end else if (go_ack) begin
              // SCL low, SDA carries the acknowledge value.
              state_r <= ST_ACK;
              ack_go_r <= 1'b1;
              run_r <= 1'b1;
              scl_oe_n_r <= 1'b0;
              sda_oe_n_r <= wd[CT_ACKV];
            end else if (go_stop) begin
              // stop begins by pulling SDA low.
              state_r <= ST_STOP;
              stop_go_r <= 1'b1;
              phase_r <= PH_SDA_WAIT;
              sda_oe_n_r <= 1'b0;
            end else if (buf_ok) begin
              // byte goes out most significant bit first.
              // a buffer write accepted in idle starts at the first bit.
              state_r <= ST_TX;
              run_r <= 1'b1;
              shift_r <= wd[7:0];
              scl_oe_n_r <= 1'b0;
              sda_oe_n_r <= wd[7];
            end
          end
          default: begin
            case (phase_r)
              PH_SDA_WAIT: begin
                if (!sda_s) begin
                  cnt_r <= reload_r;
                  run_r <= 1'b1;
                  phase_r <= PH_LOW;
                end
              end
              PH_LOW: begin
                if (tick) begin
                  scl_oe_n_r <= 1'b1;
                  run_r <= 1'b0;
                  phase_r <= PH_WAIT;
                end
              end
              PH_WAIT: begin
                // hold until SCL really reads high.
                if (scl_s) begin
                  cnt_r <= reload_r;
                  run_r <= 1'b1;
                  phase_r <= PH_HIGH;
                end
              end
              PH_HIGH: begin
                if (tick && (state_r == ST_STOP)) begin
                  // release SDA then count one more period.
                  sda_oe_n_r <= 1'b1;
                  cnt_r <= reload_r;
                  phase_r <= PH_TAIL;
                end else if (tick) begin
                  scl_oe_n_r <= 1'b0;
                  cnt_r <= reload_r;
                  phase_r <= PH_LOW;
                  bit_r <= bit_r + 4'h1;
                  if (state_r == ST_RX) begin
                    shift_r <= shift_in;
                    if (bit_r == LAST_BIT) begin
                      state_r <= ST_IDLE;
                      run_r <= 1'b0;
                      rx_go_r <= 1'b0;
                    end
                  end else if (state_r == ST_TX) begin
                    shift_r <= {shift_r[6:0], 1'b0};
                    sda_oe_n_r <= (bit_r >= LAST_BIT) ? 1'b1 : shift_r[6];
                    if (bit_r == ACK_BIT) begin
                      ackstat_r <= sda_s;
                      state_r <= ST_IDLE;
                      run_r <= 1'b0;
                    end
                  end else begin
                    state_r <= ST_IDLE;
                    run_r <= 1'b0;
                    ack_go_r <= 1'b0;
                  end
                end
              end
              default: begin
                if (tick) begin
                  state_r <= ST_IDLE;
                  run_r <= 1'b0;
                  stop_go_r <= 1'b0;
                end
              end
            endcase
          end
        endcase
      end
    end
  end
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n = scl_oe_n_r;
  assign sda_oe_n = sda_oe_n_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  rx_done_a: assert property (rx_done |=> buffer_full_r && flags_r[FL_EVENT] && !rx_go_r
    && (state_r == ST_IDLE) && !scl_oe_n_r) else $error("Receive completion wrong.");
  rx_ignore_a: assert property ((wr_ctrl && !go_free && !rx_go_r) |=> !rx_go_r)
    else $error("Receive-go taken while busy.");
  go_block_a: assert property ((wr_ctrl && !go_free && !stop_go_r && !ack_go_r)
    |=> !stop_go_r && !ack_go_r) else $error("Go bit taken while busy.");
  wrcol_keep_a: assert property ((wrcol_set && !rx_done) |=> flags_r[FL_WRCOL] && $stable(data_r))
    else $error("Write collision handling wrong.");
  ovf_set_a: assert property ((rx_done && buffer_full_r) |=> flags_r[FL_OVF])
    else $error("Overflow not flagged.");
  bf_read_a: assert property ((rd_buf && !rx_done && !buf_ok) |=> !buffer_full_r)
    else $error("Buffer read left buffer-full set.");
  stop_seen_a: assert property (stop_det |=> stop_seen_r && !start_seen_r && flags_r[FL_EVENT])
    else $error("Stop condition not recorded.");
  scl_wait_a: assert property ((phase_r == PH_WAIT && !scl_s) |=> $stable(cnt_r) && phase_r == PH_WAIT)
    else $error("Counter ran while SCL low.");
  coll_idle_a: assert property (coll |=> (state_r == ST_IDLE) && scl_oe_n_r && sda_oe_n_r
    && !buffer_full_r && flags_r[FL_COLL] && !stop_go_r && !ack_go_r) else $error("Collision not handled.");
  ack_drive_a: assert property ((state_r == ST_ACK) |-> (sda_oe_n_r == ack_value_r))
    else $error("Acknowledge value not driven.");
  stop_end_a: assert property (stop_done |=> !stop_go_r && flags_r[FL_EVENT] && sda_oe_n_r)
    else $error("Stop completion wrong.");
endmodule

// [verilog/i2m_pkg.sv]
// Constants, register layout and carrier types of the two-wire bus master sequencer.
package i2m_pkg;

  // ----------------------------------------------------------------
  // Register word indices
  // ----------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_CTRL2 = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_FLAGS = 3'h2;
  localparam logic [2:0] OFS_BUFFER = 3'h3;
  localparam logic [2:0] OFS_RELOAD = 3'h4;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CT_STOP = 2;
  localparam int CT_RX = 3;
  localparam int CT_ACK = 4;
  localparam int CT_ACKV = 5;
  localparam int ST_FULL = 0;
  localparam int ST_START = 3;
  localparam int ST_STOP_SEEN = 4;
  localparam int ST_ACKSTAT = 6;
  localparam int FL_EVENT = 0;
  localparam int FL_COLL = 1;
  localparam int FL_WRCOL = 2;
  localparam int FL_OVF = 3;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [6:0] RST_RELOAD = 7'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [31:0] writedata;
  } i2m_av_req_type;

  typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_TX, ST_ACK, ST_STOP} i2m_state_type;
  typedef enum logic [2:0] {PH_LOW, PH_WAIT, PH_HIGH, PH_SDA_WAIT, PH_TAIL} i2m_phase_type;

endpackage
